/* hdl/cbc_pkg.sv */
// Constants, register map and types for the cell balance controller
package cbc_pkg;
    localparam int CELLS = 12;
    localparam int VOLT_W = 14;
    localparam int VALUE_W = 28;
    localparam int DATA_W = 14;
    localparam int SEC_W = 12;
    localparam int INST_DEPTH = 16;
    // Timebase: one tick per second
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = TICK_S * CLK_HZ;
    localparam int DUR_UNIT_S = 20;
    localparam int WAIT_UNIT_S = 2;
    // Pages and addresses
    localparam logic [1:0] PAGE_CFG = 2'h2;
    localparam logic [1:0] PAGE_CMD = 2'h3;
    localparam logic [5:0] ADDR_SETUP = 6'h13;
    localparam logic [5:0] ADDR_STATUS = 6'h14;
    localparam logic [5:0] ADDR_TIME = 6'h15;
    localparam logic [5:0] ADDR_DEV_SETUP = 6'h19;
    localparam logic [5:0] ADDR_VALUE_BASE = 6'h20;
    localparam logic [5:0] ADDR_VALUE_LAST = 6'h37;
    localparam logic [5:0] CMD_ENABLE = 6'h10;
    localparam logic [5:0] CMD_INHIBIT = 6'h11;
    // Balance setup fields
    localparam int MODE_LSB = 0;
    localparam int WAIT_LSB = 2;
    localparam int PTR_LSB = 5;
    localparam int EN_BIT = 9;
    // Time register fields
    localparam int DUR_LSB = 7;
    localparam int WDOG_LSB = 0;
    // Device setup field
    localparam int PAUSE_BIT = 0;
    // Mode codes
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_TIMED = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;
    localparam logic [3:0] FIRST_AUTO_INST = 4'h1;
    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_APPLY, ST_RUN, ST_SUB, ST_CHECK, ST_WAIT} cbc_state_t;
endpackage

/* hdl/cbc_inst_mem.sv */
// Balance status instance store with registered read data
`timescale 1ns/1ns
module cbc_inst_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("cbc_inst_mem: unsupported size");
    end

    // Array itself is not reset; software writes each slot before use
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule // cbc_inst_mem

/* hdl/cbc_balance_ctrl.sv */
// Cell balance controller: modes, timers, instance loop and balance value countdown
// How it works
// - Mode 01 is manual: selected cells balance while enable stays set.
// - Mode 10 is timed balancing, mode 11 is automatic balancing.
// - Enable command or writing the enable bit to 1 starts balancing when the mode is not 00.
// - Clearing the enable bit or the inhibit command (page 3, 6'h11) stops it.
// - Cell-select bit 0 drives cell 1, up to bit 11 for cell 12.
// - Timed mode switches everything off once the duration has elapsed.
// - Duration code lives in bits 13:7 of the time register at 6'h15.
// - Duration code counts twenty-second units: 1=20 s, 3=1 min, 15=5 min.
// - Wait code 100 gives 8 s with switches off between instances.
// - With the pause bit set, switches stay off during measurements.
// - Status writes land in the instance chosen by the status pointer.
// - An all-zero instance ends the list; automatic mode wraps to the first.
// - Automatic mode loops over instances with the wait time between them.
// - In automatic mode, after each instance, balanced cells' voltages are subtracted from their values.
// - Automatic balancing ends when every cell's balance value is zero.
`timescale 1ns/1ns
module cbc_balance_ctrl
    import cbc_pkg::*;
#(
    parameter int TICK_LEN = cbc_pkg::TICK_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [1:0] REG_PAGE,
    input wire logic [5:0] REG_ADDR,
    input wire logic [cbc_pkg::DATA_W-1:0] REG_WDATA,
    output logic [cbc_pkg::DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic MEAS_ACTIVE,
    input wire logic [cbc_pkg::CELLS*cbc_pkg::VOLT_W-1:0] CELL_VOLTS,
    output logic [cbc_pkg::CELLS-1:0] BAL_SW,
    output logic BAL_ACTIVE
);
    import cbc_pkg::*;

    if (TICK_LEN < 1) begin : g_chk
        $error("cbc_balance_ctrl: TICK_LEN must be at least 1");
    end

    function automatic logic [VALUE_W-1:0] sat_sub(input logic [VALUE_W-1:0] a, input logic [VOLT_W-1:0] b);
        logic [VALUE_W-1:0] bw;
        bw = {{(VALUE_W-VOLT_W){1'b0}}, b};
        sat_sub = (a > bw) ? a - bw : '0;
    endfunction

    cbc_state_t state_reg, state_next;
    logic [1:0] mode_reg;
    logic [2:0] wait_code_reg;
    logic [3:0] ptr_reg, idx_reg;
    logic en_reg, pause_reg, rvalid_reg;
    logic [6:0] dur_code_reg, wdog_reg;
    logic [CELLS-1:0] mask_reg, sw_next;
    logic [VALUE_W-1:0] bv_reg [CELLS];
    logic [3:0] cidx_reg;
    logic [SEC_W-1:0] sec_reg;
    logic [31:0] tick_cnt_reg;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [CELLS-1:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of accesses and fields
    wire wr_cfg = REG_WR && (REG_PAGE == PAGE_CFG);
    wire wr_setup = wr_cfg && (REG_ADDR == ADDR_SETUP);
    wire wr_status = wr_cfg && (REG_ADDR == ADDR_STATUS);
    wire wr_time = wr_cfg && (REG_ADDR == ADDR_TIME);
    wire wr_dev = wr_cfg && (REG_ADDR == ADDR_DEV_SETUP);
    wire in_value = (REG_ADDR >= ADDR_VALUE_BASE) && (REG_ADDR <= ADDR_VALUE_LAST);
    wire [5:0] value_off = REG_ADDR - ADDR_VALUE_BASE;
    wire [3:0] value_cell = value_off[4:1];
    wire wr_value = wr_cfg && in_value;
    wire cmd_enable = REG_WR && (REG_PAGE == PAGE_CMD) && (REG_ADDR == CMD_ENABLE);
    wire cmd_inhibit = REG_WR && (REG_PAGE == PAGE_CMD) && (REG_ADDR == CMD_INHIBIT);
    wire mode_manual = (mode_reg == MODE_MANUAL);
    wire mode_timed = (mode_reg == MODE_TIMED);
    wire mode_auto = (mode_reg == MODE_AUTO);
    // Twenty-second units, so code 3 is one minute and code 15 five minutes
    wire [SEC_W-1:0] dur_s = SEC_W'({5'h0, dur_code_reg} * 12'(DUR_UNIT_S));
    wire [SEC_W-1:0] wait_s = SEC_W'({9'h0, wait_code_reg} * 12'(WAIT_UNIT_S));
    wire tick = (tick_cnt_reg == 32'(TICK_LEN - 1));
    wire dur_done = (sec_reg >= dur_s);
    wire wait_done = (sec_reg >= wait_s);
    wire [VOLT_W-1:0] cur_volt = CELL_VOLTS[cidx_reg*VOLT_W +: VOLT_W];
    logic all_zero;
    // Hardware clear of the enable: timed expiry or automatic completion
    wire hw_stop = (state_reg == ST_RUN && mode_timed && dur_done)
        || (state_reg == ST_CHECK && all_zero);
    always_comb begin
        all_zero = 1'b1;
        for (int i = 0; i < CELLS; i++) begin
            if (bv_reg[i] != '0) all_zero = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instance store; status writes go to the pointed slot
    cbc_inst_mem #(.WIDTH(CELLS), .DEPTH(INST_DEPTH)) u_mem (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .wr_en(wr_status),
        .wr_addr(ptr_reg),
        .wr_data(REG_WDATA[CELLS-1:0]),
        .rd_addr(idx_reg),
        .rd_data(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers; a host write of the enable wins over a hardware clear
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mode_reg <= 2'h0;
            wait_code_reg <= 3'h0;
            ptr_reg <= 4'h0;
            en_reg <= 1'b0;
            dur_code_reg <= 7'h00;
            wdog_reg <= 7'h7f;
            pause_reg <= 1'b0;
        end else begin
            if (wr_setup) begin
                mode_reg <= REG_WDATA[MODE_LSB +: 2];
                wait_code_reg <= REG_WDATA[WAIT_LSB +: 3];
                ptr_reg <= REG_WDATA[PTR_LSB +: 4];
                en_reg <= REG_WDATA[EN_BIT];
            end else if (cmd_enable) begin
                en_reg <= 1'b1;
            end else if (cmd_inhibit || hw_stop) begin
                en_reg <= 1'b0;
            end
            if (wr_time) begin
                dur_code_reg <= REG_WDATA[DUR_LSB +: 7];
                wdog_reg <= REG_WDATA[WDOG_LSB +: 7];
            end
            if (wr_dev) pause_reg <= REG_WDATA[PAUSE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = (en_reg && mode_reg != 2'h0) ? ST_LOAD : ST_IDLE;
            ST_LOAD: state_next = ST_APPLY;
            ST_APPLY: state_next = (mode_auto && mem_rdata == '0) ? ST_LOAD : ST_RUN;
            ST_RUN: begin
                if (mode_manual && wr_status) state_next = ST_LOAD;
                else if (mode_timed && dur_done) state_next = ST_IDLE;
                else if (mode_auto && dur_done) state_next = ST_SUB;
            end
            ST_SUB: state_next = (cidx_reg == 4'(CELLS - 1)) ? ST_CHECK : ST_SUB;
            ST_CHECK: state_next = all_zero ? ST_IDLE : ST_WAIT;
            ST_WAIT: state_next = wait_done ? ST_LOAD : ST_WAIT;
            default: state_next = ST_IDLE;
        endcase
        if (!en_reg) state_next = ST_IDLE;
    end

    // Automatic mode starts at slot one and wraps there after an empty slot
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            idx_reg <= 4'h0;
            mask_reg <= '0;
            cidx_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) idx_reg <= mode_auto ? FIRST_AUTO_INST : ptr_reg;
            else if (state_reg == ST_APPLY && mode_auto && mem_rdata == '0) idx_reg <= FIRST_AUTO_INST;
            else if (state_reg == ST_WAIT && wait_done) idx_reg <= idx_reg + 4'h1;
            else if (state_reg == ST_RUN && mode_manual) idx_reg <= ptr_reg;
            if (state_next == ST_IDLE) mask_reg <= '0;
            else if (state_reg == ST_APPLY) mask_reg <= mem_rdata;
            cidx_reg <= (state_reg == ST_SUB) ? cidx_reg + 4'h1 : 4'h0;
        end
    end

    // Second counter restarts at each phase; sub-second residue is dropped
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || state_reg == ST_APPLY || state_reg == ST_CHECK || state_reg == ST_IDLE) begin
            tick_cnt_reg <= 32'h0;
            sec_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (tick && sec_reg != '1) sec_reg <= sec_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Balance values; the countdown wins over a host write in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < CELLS; i++) bv_reg[i] <= '0;
        end else if (state_reg == ST_SUB) begin
            if (mask_reg[cidx_reg]) bv_reg[cidx_reg] <= sat_sub(bv_reg[cidx_reg], cur_volt);
        end else if (wr_value) begin
            if (value_off[0]) bv_reg[value_cell][VALUE_W-1:DATA_W] <= REG_WDATA;
            else bv_reg[value_cell][DATA_W-1:0] <= REG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch drive: bit n drives cell n+1
    assign sw_next = (en_reg && state_reg == ST_RUN && !(pause_reg && MEAS_ACTIVE)) ? mask_reg : '0;

    // Read data mux; status reads return the instance now applied
    always_comb begin
        rdata_next = '0;
        if (REG_PAGE == PAGE_CFG) begin
            if (REG_ADDR == ADDR_SETUP)
                rdata_next = DATA_W'({en_reg, ptr_reg, wait_code_reg, mode_reg});
            else if (REG_ADDR == ADDR_STATUS) rdata_next = DATA_W'(mask_reg);
            else if (REG_ADDR == ADDR_TIME) rdata_next = {dur_code_reg, wdog_reg};
            else if (REG_ADDR == ADDR_DEV_SETUP) rdata_next = DATA_W'(pause_reg);
            else if (in_value)
                rdata_next = value_off[0] ? bv_reg[value_cell][VALUE_W-1:DATA_W] : bv_reg[value_cell][DATA_W-1:0];
        end
    end

    // Output flops
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            BAL_SW <= '0;
            BAL_ACTIVE <= 1'b0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            BAL_SW <= sw_next;
            BAL_ACTIVE <= en_reg;
            rvalid_reg <= REG_RD;
            if (REG_RD) rdata_reg <= rdata_next;
        end
    end
    assign REG_RDATA = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_inhibit_off;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (cmd_inhibit && !wr_setup) |=> !en_reg ##1 (BAL_SW == '0);
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("inhibit did not stop balancing");

    property p_enable_cmd;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (cmd_enable && !REG_WR == 1'b0 && !wr_setup) |=> en_reg;
    endproperty
    a_enable_cmd: assert property (p_enable_cmd) else $error("enable command ignored");

    property p_pause_meas;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (pause_reg && MEAS_ACTIVE) |=> (BAL_SW == '0);
    endproperty
    a_pause_meas: assert property (p_pause_meas) else $error("switch on during measurement");

    property p_wait_off;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_WAIT) |=> (BAL_SW == '0);
    endproperty
    a_wait_off: assert property (p_wait_off) else $error("switch on during wait");

    property p_sw_follows;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_RUN && en_reg && !(pause_reg && MEAS_ACTIVE)) |=> (BAL_SW == $past(mask_reg));
    endproperty
    a_sw_follows: assert property (p_sw_follows) else $error("switches differ from instance");

    property p_timed_stop;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_RUN && mode_timed && dur_done && !REG_WR) |=> !en_reg ##1 (BAL_SW == '0);
    endproperty
    a_timed_stop: assert property (p_timed_stop) else $error("timed balancing did not end");

    property p_auto_done;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_CHECK && all_zero && !REG_WR) |=> !en_reg && state_reg == ST_IDLE;
    endproperty
    a_auto_done: assert property (p_auto_done) else $error("auto balancing did not terminate");

    property p_wrap;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_APPLY && mode_auto && mem_rdata == '0 && en_reg) |=> (idx_reg == FIRST_AUTO_INST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("empty instance did not wrap");

    property p_subtract;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == ST_SUB && mask_reg[cidx_reg] && bv_reg[cidx_reg] > VALUE_W'(cur_volt))
        |=> (bv_reg[$past(cidx_reg)] == $past(bv_reg[cidx_reg]) - VALUE_W'($past(cur_volt)));
    endproperty
    a_subtract: assert property (p_subtract) else $error("balance value not reduced");
endmodule // cbc_balance_ctrl

/* test/cbc_host_model.sv */
// Host side of the register bus: one access task, released lines show inverted values
`timescale 1ns/1ns
module cbc_host_model
    import cbc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic [cbc_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic REG_RVALID,
    output logic REG_WR,
    output logic REG_RD,
    output logic [1:0] REG_PAGE,
    output logic [5:0] REG_ADDR,
    output logic [cbc_pkg::DATA_W-1:0] REG_WDATA
);
    // Idle bus at time zero
    initial begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_PAGE = 2'h0;
        REG_ADDR = 6'h3f;
        REG_WDATA = '0;
    end

    // One strobe cycle; stale qualifiers are inverted so no old value lingers
    task automatic access(input logic wr, input logic [1:0] page, input logic [5:0] addr,
                          input logic [DATA_W-1:0] data, output logic [DATA_W-1:0] rdata);
        @(posedge CORE_CLK);
        REG_WR <= wr;
        REG_RD <= !wr;
        REG_PAGE <= page;
        REG_ADDR <= addr;
        REG_WDATA <= data;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        REG_PAGE <= ~page;
        REG_ADDR <= ~addr;
        REG_WDATA <= ~data;
        rdata = '0;
        if (!wr) begin
            // Valid stands in the cycle after the strobe; take it at the edge that closes that cycle
            @(posedge CORE_CLK);
            // No valid pulse means the value cannot match anything
            rdata = (REG_RVALID === 1'b1) ? REG_RDATA : 'x;
        end
    endtask
endmodule // cbc_host_model

/* test/cbc_balance_ctrl_tb_top.sv */
// Self-checking bench for the cell balance controller
`timescale 1ns/1ns
module cbc_balance_ctrl_tb_top;
    import cbc_pkg::*;
    localparam int TL = 10;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic meas_active = 1'b0;
    logic [CELLS*VOLT_W-1:0] cell_volts = '0;
    logic reg_wr, reg_rd, reg_rvalid, bal_active;
    logic [1:0] reg_page;
    logic [5:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [CELLS-1:0] bal_sw, mask;
    logic [VALUE_W-1:0] model [CELLS];
    logic [CELLS-1:0] slots [3] = '{12'h249, 12'h924, 12'h492};
    logic [6:0] durs [3] = '{7'h01, 7'h03, 7'h0f};
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, k, idx;
    logic done;

    cbc_host_model host_u (.CORE_CLK(core_clk), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_PAGE(reg_page), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
    cbc_balance_ctrl #(.TICK_LEN(TL)) dut_u (.CORE_CLK(core_clk), .RST_N(rst_n), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_PAGE(reg_page), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .MEAS_ACTIVE(meas_active),
        .CELL_VOLTS(cell_volts), .BAL_SW(bal_sw), .BAL_ACTIVE(bal_active));

    // 40 ns clock and a cycle ceiling that cuts a hang short
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            $display("mismatch timeout expected end seen hang");
            fail_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus helpers, comparisons and expectation functions
    task automatic wr(input logic [1:0] page, input logic [5:0] addr, input logic [DATA_W-1:0] d);
        host_u.access(1'b1, page, addr, d, rd_val);
    endtask
    task automatic rd(input logic [5:0] addr);
        host_u.access(1'b0, PAGE_CFG, addr, '0, rd_val);
    endtask
    task automatic chk_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic chk_sw(input string what, input logic [CELLS-1:0] exp);
        samples_checked++;
        if (bal_sw !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, bal_sw);
            fail_count++;
        end
    endtask
    task automatic chk_span(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
            fail_count++;
        end
    endtask
    // Bounded wait for the switch pattern; n is the number of cycles it took
    task automatic wait_eq(input logic [CELLS-1:0] exp, input int limit, output int cnt);
        cnt = 0;
        while (bal_sw !== exp && cnt < limit) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask
    function automatic logic [DATA_W-1:0] setup(logic [1:0] md, logic [2:0] wt, logic [3:0] ptr, logic en);
        return DATA_W'({en, ptr, wt, md});
    endfunction
    function automatic logic [VOLT_W-1:0] volt(int c);
        return cell_volts[c*VOLT_W +: VOLT_W];
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hec68282b));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_TIME);
        chk_word("time_reset", 14'h007f, rd_val);
        chk_sw("sw_reset", '0);
        rd(6'h3e);
        chk_word("unmapped", '0, rd_val);
        $display("test reset done");
        // Manual mode: enable command first, then corner cells and a random set
        wr(PAGE_CFG, ADDR_SETUP, setup(MODE_MANUAL, 3'h0, 4'h0, 1'b0));
        wr(PAGE_CFG, ADDR_STATUS, 14'h0001);
        wr(PAGE_CMD, CMD_ENABLE, '0);
        for (k = 0; k < 3; k++) begin
            mask = (k == 0) ? 12'h001 : (k == 1) ? 12'h800 : CELLS'($urandom_range(1, 4095));
            wr(PAGE_CFG, ADDR_STATUS, DATA_W'(mask));
            wait_eq(mask, 10, n);
            chk_sw("manual_sw", mask);
        end
        repeat (50) @(posedge core_clk);
        chk_sw("manual_hold", mask);
        chk_word("active_on", 14'h0001, DATA_W'(bal_active));
        rd(ADDR_STATUS);
        chk_word("status_read", DATA_W'(mask), rd_val);
        wr(PAGE_CFG, ADDR_DEV_SETUP, 14'h0001);
        @(posedge core_clk);
        meas_active <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk_sw("pause_off", '0);
        @(posedge core_clk);
        meas_active <= 1'b0;
        wait_eq(mask, 10, n);
        chk_sw("pause_back", mask);
        wr(PAGE_CFG, ADDR_DEV_SETUP, 14'h0000);
        wr(PAGE_CMD, CMD_INHIBIT, '0);
        wait_eq('0, 4, n);
        chk_sw("inhibit", '0);
        wr(PAGE_CFG, ADDR_SETUP, setup(MODE_MANUAL, 3'h0, 4'h0, 1'b1));
        wait_eq(mask, 10, n);
        chk_sw("bit_enable", mask);
        wr(PAGE_CFG, ADDR_SETUP, setup(MODE_MANUAL, 3'h0, 4'h0, 1'b0));
        wait_eq('0, 4, n);
        chk_sw("bit_clear", '0);
        wr(PAGE_CFG, ADDR_SETUP, setup(2'h0, 3'h0, 4'h0, 1'b1));
        repeat (10) @(posedge core_clk);
        chk_sw("mode0_idle", '0);
        wr(PAGE_CFG, ADDR_SETUP, setup(2'h0, 3'h0, 4'h0, 1'b0));
        $display("test manual done");
        // Timed mode over three duration codes
        for (k = 0; k < 3; k++) begin
            wr(PAGE_CFG, ADDR_TIME, {durs[k], 7'h7f});
            rd(ADDR_TIME);
            chk_word("time_reg", {durs[k], 7'h7f}, rd_val);
            wr(PAGE_CFG, ADDR_SETUP, setup(MODE_TIMED, 3'h0, 4'h0, 1'b0));
            wr(PAGE_CFG, ADDR_STATUS, 14'h0082);
            wr(PAGE_CMD, CMD_ENABLE, '0);
            wait_eq(12'h082, 10, n);
            chk_sw("timed_on", 12'h082);
            wait_eq('0, 4000, n);
            chk_span("timed_len", durs[k] * 20 * TL - 2, durs[k] * 20 * TL + 4, n);
        end
        $display("test timed done");
        // Automatic mode: random voltages, values reachable within three loops
        for (k = 0; k < CELLS; k++) begin
            @(posedge core_clk);
            cell_volts[k*VOLT_W +: VOLT_W] <= VOLT_W'($urandom_range(500, 4000));
            #1;
            model[k] = VALUE_W'(volt(k) * $urandom_range(1, 3) - $urandom_range(0, 499));
            wr(PAGE_CFG, ADDR_VALUE_BASE + 6'(2 * k), model[k][13:0]);
            wr(PAGE_CFG, ADDR_VALUE_BASE + 6'(2 * k + 1), model[k][27:14]);
        end
        wr(PAGE_CFG, ADDR_TIME, {7'h01, 7'h7f});
        for (k = 0; k < 4; k++) begin
            wr(PAGE_CFG, ADDR_SETUP, setup(MODE_AUTO, 3'h4, 4'(k + 1), 1'b0));
            wr(PAGE_CFG, ADDR_STATUS, (k < 3) ? DATA_W'(slots[k]) : '0);
        end
        wr(PAGE_CMD, CMD_ENABLE, '0);
        done = 1'b0;
        idx = 0;
        for (k = 0; k < 12 && !done; k++) begin
            wait_eq(slots[idx], 150, n);
            chk_sw("auto_inst", slots[idx]);
            rd(ADDR_VALUE_BASE);
            chk_word("value_cell1", model[0][13:0], rd_val);
            wait_eq('0, 400, n);
            chk_span("auto_on", 20 * TL - 8, 20 * TL + 4, n);
            done = 1'b1;
            for (int c = 0; c < CELLS; c++) begin
                if (slots[idx][c]) model[c] = (model[c] > volt(c)) ? model[c] - volt(c) : '0;
                if (model[c] != 0) done = 1'b0;
            end
            idx = (idx + 1) % 3;
            if (!done) begin
                wait_eq(slots[idx], 150, n);
                chk_span("auto_wait", 8 * TL, 8 * TL + 30, n);
            end
        end
        repeat (150) @(posedge core_clk);
        #1;
        chk_sw("auto_end", '0);
        chk_word("auto_active", '0, DATA_W'(bal_active));
        for (k = 0; k < 2 * CELLS; k++) begin
            rd(ADDR_VALUE_BASE + 6'(k));
            chk_word("value_end", '0, rd_val);
        end
        $display("test auto done");
        wrap_up();
    end
endmodule // cbc_balance_ctrl_tb_top
